// ==== frs_host_seq.sv ====
`include "frs_params.svh"
module frs_host_seq (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic supplyGood,
  input  wire logic resetReq,
  input  wire logic wakeReq,
  input  wire logic accessReq,
  input  wire logic busyIndicator_n,
  output logic      flashReset_n,
  output logic      flashSelect_n,
  output logic      linkReady,
  output logic      flashBusy
);
  frs_pkg::frs_regs_t sReg;
  frs_pkg::frs_regs_t sNext;

  localparam logic [15:0] SupplyCyc = 16'(`FRS_SUPPLY_CYC);
  localparam logic [15:0] RecovCyc  = 16'(`FRS_RECOVERY_CYC);
  localparam logic [15:0] PulseCyc  = 16'(`FRS_PULSE_CYC);
  localparam logic [15:0] RhCyc     = 16'(`FRS_RH_CYC);
  localparam logic [15:0] WakeCyc   = 16'(`FRS_WAKE_CYC);
  localparam int          RecovSpan = `FRS_RECOVERY_CYC;

  function automatic logic inReset(frs_pkg::frs_state_t s);
    return (s == frs_pkg::FRS_PULSE) || (s == frs_pkg::FRS_RECOV);
  endfunction : inReset

  always_comb begin
    sNext = sReg;
    // Supply setup runs from supplyGood regardless of the reset pulse
    if (!supplyGood) begin
      sNext.supplyCnt  = 16'h0000;
      sNext.supplyDone = 1'b0;
    end else if (!sReg.supplyDone) begin
      sNext.supplyCnt = sReg.supplyCnt + 16'h0001;
      if (sReg.supplyCnt + 16'h0001 >= SupplyCyc) begin
        sNext.supplyDone = 1'b1;
      end
    end
    if (sReg.cnt != 16'hffff) begin
      sNext.cnt = sReg.cnt + 16'h0001;
    end
    unique case (sReg.state)
      frs_pkg::FRS_POWER: begin
        sNext.pins.chipEnable_n = 1'b1;
        sNext.pins.ready        = 1'b0;
        // A pin left low by a supply loss still owes a full recovery
        if (resetReq || !sReg.pins.resetOut_n) begin
          sNext.state           = frs_pkg::FRS_PULSE;
          sNext.cnt             = 16'h0000;
          sNext.pins.resetOut_n = 1'b0;
        end else if (sReg.supplyDone) begin
          sNext.state = frs_pkg::FRS_HIGH;
          sNext.cnt   = 16'h0000;
        end
      end
      frs_pkg::FRS_PULSE: begin
        // Recovery restarts at setup end if reset still low
        if (supplyGood && !sReg.supplyDone) begin
          sNext.cnt = 16'h0000;
        end else if (sReg.cnt + 16'h0001 >= PulseCyc && !resetReq) begin
          sNext.state           = frs_pkg::FRS_RECOV;
          sNext.pins.resetOut_n = 1'b1;
        end
      end
      frs_pkg::FRS_RECOV: begin
        // Counter keeps running from reset fall, so sum covers recovery
        if (sReg.cnt + 16'h0001 >= RecovCyc + RhCyc) begin
          sNext.state = frs_pkg::FRS_HIGH;
          sNext.cnt   = 16'h0000;
        end
      end
      frs_pkg::FRS_HIGH: begin
        if (sReg.cnt + 16'h0001 >= RhCyc && sReg.supplyDone) begin
          sNext.state      = frs_pkg::FRS_READY;
          sNext.pins.ready = 1'b1;
        end
      end
      frs_pkg::FRS_READY: begin
        sNext.pins.chipEnable_n = !accessReq;
        if (wakeReq) begin
          sNext.state = frs_pkg::FRS_WAKE;
          sNext.cnt   = 16'h0000;
          sNext.pins.ready = 1'b0;
        end
      end
      frs_pkg::FRS_WAKE: begin
        sNext.pins.chipEnable_n = 1'b0;
        if (sReg.cnt + 16'h0001 >= WakeCyc) begin
          sNext.state      = frs_pkg::FRS_READY;
          sNext.pins.ready = 1'b1;
        end
      end
      default: sNext.state = frs_pkg::FRS_POWER;
    endcase
    if (resetReq && sReg.state != frs_pkg::FRS_POWER && sReg.state != frs_pkg::FRS_PULSE) begin
      sNext.state             = frs_pkg::FRS_PULSE;
      sNext.cnt               = 16'h0000;
      sNext.pins.resetOut_n   = 1'b0;
      sNext.pins.chipEnable_n = 1'b1;
      sNext.pins.ready        = 1'b0;
    end
    if (!supplyGood) begin
      sNext.state             = frs_pkg::FRS_POWER;
      sNext.pins.chipEnable_n = 1'b1;
      sNext.pins.ready        = 1'b0;
    end
    sNext.busySeen = !busyIndicator_n;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sReg <= '{state: frs_pkg::FRS_POWER, cnt: 16'h0000, supplyCnt: 16'h0000,
                supplyDone: 1'b0, pins: 3'b110, busySeen: 1'b0};
    end else begin
      sReg <= sNext;
    end
  end

  assign flashReset_n  = sReg.pins.resetOut_n;
  assign flashSelect_n = sReg.pins.chipEnable_n;
  assign linkReady     = sReg.pins.ready;
  assign flashBusy     = sReg.busySeen;

  sequence selLowNow;
    $fell(flashSelect_n);
  endsequence

  first_access_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    selLowNow |-> sReg.supplyDone) else $error("select before supply setup");
  pulse_width_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(flashReset_n) |=> !flashReset_n) else $error("reset pulse short");
  recovery_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(flashReset_n) |-> !selLowNow) else $error("select at reset release");
  sel_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !supplyGood |=> flashSelect_n) else $error("select low without supply");
  ready_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    linkReady |-> flashReset_n) else $error("ready during reset");
  wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sReg.state == frs_pkg::FRS_WAKE) |-> !linkReady) else $error("ready in wake");
  reset_req_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (resetReq && supplyGood) |=> !flashReset_n) else $error("reset not driven");
  busy_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !busyIndicator_n |=> flashBusy) else $error("busy not reported");

  sequence resetFallNow;
    $fell(flashReset_n);
  endsequence

  sequence resetRiseNow;
    $rose(flashReset_n);
  endsequence

  // Select must stay high for the whole recovery span after a fall
  sel_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resetFallNow |-> not (##[0:RecovSpan] selLowNow)) else $error("select inside recovery");

  pulse_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    inReset(sReg.state) |-> flashSelect_n) else $error("select low in reset");

  recov_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sReg.state == frs_pkg::FRS_RECOV) |-> !linkReady) else $error("ready in recovery");

  rise_high_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    resetRiseNow |-> (flashSelect_n && !linkReady)) else $error("select at release");

  high_state_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sReg.state == frs_pkg::FRS_HIGH) |-> (flashReset_n && flashSelect_n)) else $error("high time broken");

  pulse_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sReg.state == frs_pkg::FRS_PULSE) |-> !flashReset_n) else $error("reset high in pulse");

  supply_ready_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    linkReady |-> sReg.supplyDone) else $error("ready before setup");

  // Recovery may not start until the supply setup has ended
  por_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sReg.supplyDone |-> (sReg.state != frs_pkg::FRS_RECOV)) else $error("recovery before setup");

  sel_cold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !sReg.supplyDone |-> flashSelect_n) else $error("select low in setup");

  ready_state_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    linkReady |-> (sReg.state == frs_pkg::FRS_READY)) else $error("ready outside idle");

  reset_state_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !flashReset_n |-> (inReset(sReg.state) || sReg.state == frs_pkg::FRS_POWER))
    else $error("reset low out of place");

  wake_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((sReg.state == frs_pkg::FRS_WAKE) && $past(sReg.state == frs_pkg::FRS_WAKE)) |-> !flashSelect_n)
    else $error("select high in wake");

  busy_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busyIndicator_n |=> !flashBusy) else $error("busy stuck");
endmodule : frs_host_seq

// ==== frs_params.svh ====
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH

`define FRS_CLK_NS             100
`define FRS_SUPPLY_SETUP_US    300
`define FRS_RECOVERY_US        35
`define FRS_PULSE_NS           200
`define FRS_HIGH_TO_SELECT_NS  50
`define FRS_SLEEP_STANDBY_US   8
`define FRS_SUPPLY_CYC   ((`FRS_SUPPLY_SETUP_US * 1000 + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_RECOVERY_CYC ((`FRS_RECOVERY_US * 1000 + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_PULSE_CYC    ((`FRS_PULSE_NS + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_RH_CYC       ((`FRS_HIGH_TO_SELECT_NS + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_WAKE_CYC     ((`FRS_SLEEP_STANDBY_US * 1000 + `FRS_CLK_NS - 1) / `FRS_CLK_NS)
`define FRS_CNT_W        16

`endif

// ==== frs_pkg.sv ====
package frs_pkg;
  typedef enum logic [2:0] {
    FRS_POWER  = 3'b000,
    FRS_PULSE  = 3'b001,
    FRS_RECOV  = 3'b010,
    FRS_HIGH   = 3'b011,
    FRS_READY  = 3'b100,
    FRS_WAKE   = 3'b101
  } frs_state_t;

  typedef struct packed {
    logic resetOut_n;
    logic chipEnable_n;
    logic ready;
  } frs_pins_t;

  typedef struct packed {
    frs_state_t      state;
    logic [15:0]     cnt;
    logic [15:0]     supplyCnt;
    logic            supplyDone;
    frs_pins_t       pins;
    logic            busySeen;
  } frs_regs_t;
endpackage : frs_pkg

// ==== frs_dev_model.sv ====
module frs_dev_model (
  input  wire logic sys_clk,
  input  wire logic supplyGood,
  input  wire logic reset_n,
  output logic      busyIndicator_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt = 3000;
  logic lastRst = 1'b1;
  always @(posedge sys_clk) begin
    lastRst <= reset_n;
    if (!supplyGood) cnt <= 3000;
    else if (cnt > 0) cnt <= cnt - 1;
    else if (!reset_n && lastRst) cnt <= 350;
  end
  // Warm reset starts on the fall only; a held low still reports not busy once the 350-cycle count ends
  // No address pins here, so sleep and wake cost only the host's hold time
  assign busyIndicator_n = (cnt == 0);
endmodule : frs_dev_model

// ==== frs_host_seq_bench.sv ====
module frs_host_seq_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst_n = 0, supplyGood = 0, resetReq = 0, accessReq = 0, wakeReq = 0;
  logic busyIndicator_n, flashReset_n, flashSelect_n, linkReady, flashBusy;
  int   bad_count = 0;
  int   checks_done = 0;
  always #50 sys_clk = ~sys_clk;
  frs_host_seq i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .supplyGood(supplyGood),
    .resetReq(resetReq), .wakeReq(wakeReq), .accessReq(accessReq),
    .busyIndicator_n(busyIndicator_n), .flashReset_n(flashReset_n),
    .flashSelect_n(flashSelect_n), .linkReady(linkReady), .flashBusy(flashBusy));
  frs_dev_model i_dev (.sys_clk(sys_clk), .supplyGood(supplyGood),
    .reset_n(flashReset_n), .busyIndicator_n(busyIndicator_n));
  task automatic check(input string what, input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wait_ready(output int k);
    k = 0;
    while (linkReady !== 1'b1 && k < 4000) begin
      check("select idle", flashSelect_n, 1'b1);
      cyc(1);
      k++;
    end
  endtask : wait_ready
  task automatic t_power;
    int k;
    @(posedge sys_clk) supplyGood <= 1'b1;
    cyc(1000);
    check("busy in cold", flashBusy, 1'b1);
    wait_ready(k);
    check("setup waited", k + 1000 >= 3000, 1'b1);
    check("setup bounded", k + 1000 <= 3010, 1'b1);
  endtask : t_power
  task automatic t_reset;
    int k;
    @(posedge sys_clk) resetReq <= 1'b1;
    cyc(3);
    check("reset pin", flashReset_n, 1'b0);
    check("ready dropped", linkReady, 1'b0);
    check("busy in warm", flashBusy, 1'b1);
    @(posedge sys_clk) resetReq <= 1'b0;
    #1;
    wait_ready(k);
    check("recovery waited", k + 4 >= 350, 1'b1);
    check("busy cleared", flashBusy, 1'b0);
  endtask : t_reset
  task automatic t_wake;
    @(posedge sys_clk) wakeReq <= 1'b1;
    @(posedge sys_clk) wakeReq <= 1'b0;
    cyc(2);
    check("wake select", flashSelect_n, 1'b0);
    check("wake not ready", linkReady, 1'b0);
    cyc(77);
    check("wake still held", linkReady, 1'b0);
    cyc(1);
    check("wake done", linkReady, 1'b1);
  endtask : t_wake
  task automatic t_drop;
    @(posedge sys_clk) supplyGood <= 1'b0;
    cyc(2);
    check("drop select", flashSelect_n, 1'b1);
    check("drop ready", linkReady, 1'b0);
    check("drop busy", flashBusy, 1'b1);
  endtask : t_drop
  task automatic t_access;
    @(posedge sys_clk) accessReq <= 1'b1;
    cyc(2);
    check("select on access", flashSelect_n, 1'b0);
    @(posedge sys_clk) resetReq <= 1'b1;
    cyc(2);
    check("reset wins", flashSelect_n, 1'b1);
    @(posedge sys_clk) begin
      resetReq  <= 1'b0;
      accessReq <= 1'b0;
    end
  endtask : t_access
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial begin
    cyc(2);
    @(posedge sys_clk) rst_n <= 1'b1;
    t_power;
    t_wake;
    t_reset;
    t_access;
    t_reset;
    t_drop;
    wrap_up;
  end
  // Whole run is about 3800 cycles; margin for a slow ready
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    wrap_up;
  end
endmodule : frs_host_seq_bench
